// file: rtl/wsw_ctrl.sv
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module wsw_ctrl
    import wsw_pkg::*;
#(
    parameter int BASE_TICKS = 16,
    parameter int IRQ_SRCS = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // configuration word, static straps
    input wire logic [7:0] watchdog_config_word,
    input wire logic [1:0] osc_mode,
    // core instruction strobes and state
    input wire logic sleep_instr,
    input wire logic watchdog_clear_instr,
    input wire logic global_irq_enable,
    input wire logic [20:0] core_pc,
    // wake sources: each clockless-capable source flag and its enable
    input wire logic [IRQ_SRCS-1:0] irq_flag,
    input wire logic [IRQ_SRCS-1:0] irq_enable,
    input wire logic external_reset_pin,
    // watchdog oscillator, free running
    input wire logic wdog_osc,
    // power and core control
    output logic osc_driver_off,
    output logic io_hold,
    output logic core_stall,
    output logic wake_resume,
    output logic wake_vector,
    output logic device_reset_req,
    output logic [20:0] prefetch_addr,
    output logic power_down_flag,
    output logic time_out_flag
);
    initial begin
        if (IRQ_SRCS < 1) $error("IRQ_SRCS must be at least 1");
    end

    localparam logic [10:0] OST_LAST = 11'(OST_OSC_PERIODS - 1);
    localparam logic [20:0] PC_STEP = 21'h0_0002;

    typedef struct packed {
        logic [7:0] swc;
        logic pd;
        logic to;
        wsw_pwr_t pwr;
        logic [10:0] ost;
        logic [7:0] rdata;
        logic clear_p;
        logic resume;
        logic vector;
        logic rst_req;
        logic [20:0] pf;
    } wsw_ctrl_t;

    wsw_ctrl_t st_r;
    wsw_ctrl_t st_nxt;
    wsw_wdog_if wd ();
    logic tick;
    logic cfg_en;
    logic wd_run;
    logic [2:0] ratio;
    logic irq_pend;
    logic crystal;

    wsw_osc_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .osc_in(wdog_osc),
        .tick(tick)
    );

    wsw_wdog_cnt #(.BASE_TICKS(BASE_TICKS)) u_cnt (
        .ref_clk(ref_clk),
        .reset(reset),
        .base_tick(tick),
        .wd(wd)
    );

    // watchdog enable and ratio selection
    always_comb begin
        cfg_en = watchdog_config_word[CFG_EN_BIT];
        wd_run = cfg_en | st_r.swc[SWC_EN_BIT];
        // config codes run 000=1:128 down to 111=1:1, software codes the other way round
        if (cfg_en) begin
            ratio = ~watchdog_config_word[CFG_PS_MSB:CFG_PS_LSB];
        end else begin
            ratio = st_r.swc[SWC_PS_MSB:SWC_PS_LSB];
        end
    end

    // enabled flags only, global enable deliberately ignored for wake
    assign irq_pend = |(irq_flag & irq_enable);
    assign crystal = (osc_mode == OSC_HS) || (osc_mode == OSC_LP);

    assign wd.run = wd_run;
    assign wd.ratio = ratio;
    assign wd.clear = st_r.clear_p;

    // power sequencing, flags and register port
    always_comb begin
        st_nxt = st_r;
        st_nxt.clear_p = 1'b0;
        st_nxt.resume = 1'b0;
        st_nxt.vector = 1'b0;
        st_nxt.rst_req = 1'b0;
        if (reg_wr && reg_addr == ADDR_SW_WDOG_CTRL) begin
            st_nxt.swc = reg_wdata & SWC_IMPL_MASK;
        end
        if (watchdog_clear_instr) begin
            st_nxt.clear_p = 1'b1;
        end
        case (st_r.pwr)
            PWR_RUN: begin
                if (wd.expire) begin
                    st_nxt.rst_req = 1'b1;
                    st_nxt.to = 1'b0;
                end else if (sleep_instr && !irq_pend) begin
                    st_nxt.clear_p = 1'b1;
                    st_nxt.pd = 1'b0;
                    st_nxt.to = 1'b1;
                    st_nxt.pf = core_pc + PC_STEP;
                    st_nxt.pwr = PWR_SLEEP;
                end else if (sleep_instr) begin
                    st_nxt.pf = core_pc + PC_STEP;
                end
            end
            PWR_SLEEP: begin
                // a flag already pending in the sleep cycle itself makes the sleep a nop in PWR_RUN, later flags are served here
                if (external_reset_pin) begin
                    st_nxt.rst_req = 1'b1;
                    st_nxt.pwr = PWR_RUN;
                end else if (wd.expire || irq_pend) begin
                    if (wd.expire) begin
                        st_nxt.to = 1'b0;
                    end
                    st_nxt.vector = irq_pend & global_irq_enable;
                    st_nxt.ost = '0;
                    if (crystal) begin
                        st_nxt.pwr = PWR_OST;
                    end else begin
                        st_nxt.resume = 1'b1;
                        st_nxt.pwr = PWR_RUN;
                    end
                end
            end
            PWR_OST: begin
                // counts system clocks as oscillator periods once the crystal restarts
                if (external_reset_pin) begin
                    st_nxt.rst_req = 1'b1;
                    st_nxt.pwr = PWR_RUN;
                end else if (st_r.ost == OST_LAST) begin
                    st_nxt.resume = 1'b1;
                    st_nxt.vector = st_r.vector;
                    st_nxt.pwr = PWR_RUN;
                end else begin
                    st_nxt.ost = st_r.ost + 11'h001;
                    st_nxt.vector = st_r.vector;
                end
            end
            default: begin
                st_nxt.pwr = PWR_RUN;
            end
        endcase
        // read data stands one cycle after the strobe
        st_nxt.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == ADDR_SW_WDOG_CTRL) begin
                st_nxt.rdata = st_r.swc & SWC_IMPL_MASK;
            end else if (reg_addr == ADDR_RESET_CAUSE) begin
                st_nxt.rdata[RCC_PD_BIT] = st_r.pd;
                st_nxt.rdata[RCC_TO_BIT] = st_r.to;
            end else if (reg_addr == ADDR_CONFIG_WORD) begin
                st_nxt.rdata = watchdog_config_word;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end
    end

    // power-up sets both flags; time-out set until an expiry clears it
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.swc <= SWC_RESET;
            st_r.pd <= 1'b1;
            st_r.to <= 1'b1;
            st_r.pwr <= PWR_RUN;
        end else begin
            st_r <= st_nxt;
        end
    end

    // pins hold through sleep and start-up wait, driver stops in sleep only
    assign osc_driver_off = (st_r.pwr == PWR_SLEEP);
    assign io_hold = (st_r.pwr != PWR_RUN);
    assign core_stall = (st_r.pwr != PWR_RUN);
    assign wake_resume = st_r.resume;
    assign wake_vector = st_r.vector & st_r.resume;
    assign device_reset_req = st_r.rst_req;
    assign prefetch_addr = st_r.pf;
    assign power_down_flag = st_r.pd;
    assign time_out_flag = st_r.to;
    assign reg_rdata = st_r.rdata;
endmodule : wsw_ctrl

// file: rtl/wsw_pkg.sv
package wsw_pkg;
    // register map of the plain software port
    localparam logic [1:0] ADDR_SW_WDOG_CTRL = 2'h0; // software_watchdog_control
    localparam logic [1:0] ADDR_RESET_CAUSE = 2'h1; // reset_cause_control
    localparam logic [1:0] ADDR_CONFIG_WORD = 2'h2; // watchdog_config_word, read only

    // software_watchdog_control layout
    localparam int SWC_EN_BIT = 0;
    localparam int SWC_PS_LSB = 1;
    localparam int SWC_PS_MSB = 3;
    localparam logic [7:0] SWC_RESET = 8'h00;
    localparam logic [7:0] SWC_IMPL_MASK = 8'h0f;

    // reset_cause_control layout
    localparam int RCC_PD_BIT = 2;
    localparam int RCC_TO_BIT = 3;

    // watchdog_config_word layout
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_PS_LSB = 1;
    localparam int CFG_PS_MSB = 3;

    // ratio code that means 1:128 in the configuration field
    localparam logic [2:0] CFG_PS_DEFAULT = 3'h0;

    // oscillator start-up wait in crystal modes
    localparam int OST_OSC_PERIODS = 1024;

    // clock source codes
    localparam logic [1:0] OSC_RC = 2'h3;
    localparam logic [1:0] OSC_HS = 2'h2;
    localparam logic [1:0] OSC_EC = 2'h1;
    localparam logic [1:0] OSC_LP = 2'h0;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_OST
    } wsw_pwr_t;
endpackage : wsw_pkg

// file: rtl/wsw_wdog_if.sv
`timescale 1ns/1ps
// link between the control block and the watchdog counter
interface wsw_wdog_if;
    logic run;
    logic clear;
    logic [2:0] ratio;
    logic expire;
    modport ctrl (output run, output clear, output ratio, input expire);
    modport cnt (input run, input clear, input ratio, output expire);
endinterface : wsw_wdog_if

// file: rtl/wsw_wdog_cnt.sv
`timescale 1ns/1ps
// watchdog base period and postscaler, counted on the system clock via a tick
module wsw_wdog_cnt
    import wsw_pkg::*;
#(
    parameter int BASE_TICKS = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // base tick from the watchdog oscillator, already in this domain
    input wire logic base_tick,
    // control side
    wsw_wdog_if.cnt wd
);
    initial begin
        if (BASE_TICKS < 1 || BASE_TICKS > 65536) $error("BASE_TICKS must be 1 to 65536");
    end

    typedef struct packed {
        logic [15:0] base;
        logic [6:0] post;
        logic expire;
    } wsw_cnt_t;

    wsw_cnt_t st_r;
    wsw_cnt_t st_nxt;
    logic [6:0] post_top;

    // code n gives 2**n base periods
    assign post_top = 7'((8'd1 << wd.ratio) - 8'd1);

    // base period counts ticks, postscaler counts base periods
    always_comb begin
        st_nxt = st_r;
        st_nxt.expire = 1'b0;
        if (wd.clear || !wd.run) begin
            st_nxt.base = '0;
            st_nxt.post = '0;
        end else if (base_tick) begin
            if (st_r.base == 16'(BASE_TICKS - 1)) begin
                st_nxt.base = '0;
                if (st_r.post >= post_top) begin
                    st_nxt.post = '0;
                    st_nxt.expire = 1'b1;
                end else begin
                    st_nxt.post = st_r.post + 7'h01;
                end
            end else begin
                st_nxt.base = st_r.base + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wd.expire = st_r.expire;
endmodule : wsw_wdog_cnt

// file: rtl/wsw_osc_sync.sv
`timescale 1ns/1ps
// two-flop capture of the watchdog oscillator level, one pulse per rising edge
module wsw_osc_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // raw oscillator level
    input wire logic osc_in,
    // one-cycle pulse per oscillator rising edge
    output logic tick
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } wsw_sync_t;

    wsw_sync_t st_r;
    wsw_sync_t st_nxt;

    // only s2 and s3 feed the edge detector, s1 is the metastable stage
    always_comb begin
        st_nxt.s1 = osc_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.s2 & ~st_r.s3;
endmodule : wsw_osc_sync

// file: sim/wsw_ctrl_props.sv
`timescale 1ns/1ps
// port-level watch on the watchdog and sleep control block
module wsw_ctrl_props
    import wsw_pkg::*;
#(
    parameter int IRQ_SRCS = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // watched inputs
    input wire logic [1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [1:0] osc_mode,
    input wire logic sleep_instr,
    input wire logic global_irq_enable,
    input wire logic [20:0] core_pc,
    input wire logic [IRQ_SRCS-1:0] irq_flag,
    input wire logic [IRQ_SRCS-1:0] irq_enable,
    input wire logic external_reset_pin,
    // watched outputs
    input wire logic [7:0] reg_rdata,
    input wire logic osc_driver_off,
    input wire logic io_hold,
    input wire logic core_stall,
    input wire logic wake_resume,
    input wire logic wake_vector,
    input wire logic device_reset_req,
    input wire logic [20:0] prefetch_addr,
    input wire logic power_down_flag,
    input wire logic time_out_flag
);
    // single domain, so one clocking and one disable serve every property
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // an expiry in the same cycle wins, so a reset request excuses the sleep actions
    a_sleep_entry: assert property (
        sleep_instr && !core_stall && !(|(irq_flag & irq_enable)) |=> device_reset_req
        || (!power_down_flag && time_out_flag && osc_driver_off && io_hold))
        else $error("sleep entry actions missing");
    a_pending_nop: assert property (
        sleep_instr && !core_stall && |(irq_flag & irq_enable)
        |=> !io_hold && $stable(power_down_flag))
        else $error("sleep with pending source did not act as nop");
    a_prefetch_pc: assert property (
        sleep_instr && !core_stall |=> prefetch_addr == $past(core_pc) + 21'h0_0002)
        else $error("prefetch address wrong");
    // crystal modes add the start-up wait, so only the fast modes are bounded here
    a_irq_wake: assert property (
        io_hold && osc_driver_off && |(irq_flag & irq_enable) && !external_reset_pin
        && (osc_mode == OSC_RC || osc_mode == OSC_EC) |=> wake_resume && !device_reset_req)
        else $error("enabled source did not wake");
    a_vector_gie: assert property (
        wake_vector |-> wake_resume && $past(global_irq_enable))
        else $error("vector without resume or global enable");
    a_pin_reset: assert property (
        osc_driver_off && external_reset_pin |=> device_reset_req && !wake_resume)
        else $error("reset pin in sleep did not reset");
    a_expiry_reset: assert property (
        device_reset_req && !$past(io_hold) |-> !time_out_flag)
        else $error("time-out flag not cleared on expiry");
    a_upper_zero: assert property (
        reg_rd && reg_addr == ADDR_SW_WDOG_CTRL |=> reg_rdata[7:4] == 4'h0)
        else $error("unimplemented control bits read nonzero");
endmodule : wsw_ctrl_props

bind wsw_ctrl wsw_ctrl_props #(.IRQ_SRCS(IRQ_SRCS)) wsw_ctrl_props_inst (
    .ref_clk, .reset, .reg_addr, .reg_rd, .osc_mode, .sleep_instr, .global_irq_enable,
    .core_pc, .irq_flag, .irq_enable, .external_reset_pin, .reg_rdata, .osc_driver_off,
    .io_hold, .core_stall, .wake_resume, .wake_vector, .device_reset_req, .prefetch_addr,
    .power_down_flag, .time_out_flag
);

// file: sim/wsw_far_model.sv
`timescale 1ns/1ps
// far side: free running watchdog oscillator and clockless wake sources
module wsw_far_model #(
    parameter int OSC_HALF_NS = 170
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // source events raised by the bench
    input wire logic [3:0] src_req,
    // toward the block
    output logic [3:0] irq_flag,
    output logic wdog_osc
);
    // own rc oscillator, unrelated in phase and never stopped by sleep
    initial wdog_osc = 1'b0;
    always #(OSC_HALF_NS) wdog_osc = ~wdog_osc;
    // flag lands a cycle after the event, as an asynchronous peripheral would
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_flag <= 4'h0;
        end else begin
            irq_flag <= src_req;
        end
    end
endmodule : wsw_far_model

// file: sim/tb_wsw_ctrl.sv
`timescale 1ns/1ps
// register, watchdog and sleep tests through the block's own ports
module tb_wsw_ctrl
    import wsw_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] watchdog_config_word = 8'h00;
    logic [1:0] osc_mode = OSC_RC;
    logic sleep_instr = 1'b0;
    logic watchdog_clear_instr = 1'b0;
    logic global_irq_enable = 1'b1;
    logic [20:0] core_pc = 21'h1f_fffe; // plus two wraps to zero
    logic [3:0] irq_enable = 4'h0;
    logic [3:0] src_req = 4'h0;
    logic external_reset_pin = 1'b0;
    logic [3:0] irq_flag;
    logic [7:0] reg_rdata;
    logic [20:0] prefetch_addr;
    logic wdog_osc, osc_driver_off, io_hold, core_stall, wake_resume, wake_vector;
    logic device_reset_req, power_down_flag, time_out_flag;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int osc_edges = 0;
    int k;

    // short base period keeps the 1:128 run near two thousand cycles
    wsw_ctrl #(.BASE_TICKS(2), .IRQ_SRCS(4)) wsw_ctrl_inst (
        .ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .watchdog_config_word, .osc_mode, .sleep_instr, .watchdog_clear_instr,
        .global_irq_enable, .core_pc, .irq_flag, .irq_enable, .external_reset_pin,
        .wdog_osc, .osc_driver_off, .io_hold, .core_stall, .wake_resume, .wake_vector,
        .device_reset_req, .prefetch_addr, .power_down_flag, .time_out_flag
    );
    wsw_far_model #(.OSC_HALF_NS(170)) wsw_far_model_inst (
        .ref_clk, .reset, .src_req, .irq_flag, .wdog_osc
    );

    // clock, oscillator edge count and hang guard
    always #20 ref_clk = ~ref_clk;
    always @(posedge wdog_osc) osc_edges++;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rd_chk

    // one-cycle sleep (slp=1) or watchdog clear (slp=0) strobe
    task automatic pulse(input logic slp);
        @(posedge ref_clk);
        sleep_instr <= slp;
        watchdog_clear_instr <= !slp;
        @(posedge ref_clk);
        sleep_instr <= 1'b0;
        watchdog_clear_instr <= 1'b0;
        #1;
    endtask : pulse

    // bounded wait for a reset request (req=1) or a resume pulse
    task automatic wait_hi(input int lim, input logic req);
        for (k = 0; k < lim && (req ? device_reset_req : wake_resume) !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : wait_hi

    // stop and clear first so no old expiry lands inside the measurement
    task automatic measure(input logic [7:0] swc, input int n);
        wr(ADDR_SW_WDOG_CTRL, 8'h00);
        pulse(1'b0);
        wr(ADDR_SW_WDOG_CTRL, swc);
        osc_edges = 0;
        wait_hi(3000, 1'b1);
        check(osc_edges >= n - 1 && osc_edges <= n + 1, 1'b1);
        check(time_out_flag, 1'b0);
    endtask : measure

    task automatic reset_with(input logic [7:0] c, input logic [1:0] m);
        @(posedge ref_clk);
        reset <= 1'b1;
        watchdog_config_word <= c;
        osc_mode <= m;
        @(posedge ref_clk);
        reset <= 1'b0;
    endtask : reset_with

    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        irq_enable <= 4'h1;
        src_req <= 4'h1;
        repeat (2) @(posedge ref_clk);
        pulse(1'b1);
        check({io_hold, power_down_flag}, 2'h1);
        check(prefetch_addr, 21'h0_0000);
        @(posedge ref_clk) src_req <= 4'h0;
        rd_chk(ADDR_RESET_CAUSE, 8'h0c);
        rd_chk(ADDR_SW_WDOG_CTRL, SWC_RESET);
        wr(ADDR_SW_WDOG_CTRL, 8'hff);
        rd_chk(ADDR_SW_WDOG_CTRL, 8'h0f);
        wr(ADDR_RESET_CAUSE, 8'h00);
        rd_chk(ADDR_RESET_CAUSE, 8'h0c);
        rd_chk(2'h3, 8'h00);
        for (int r = 0; r < 4; r++) begin
            measure({4'h0, r[2:0], 1'b1}, 2 << r);
        end
        measure(8'h0f, 256);
        wr(ADDR_SW_WDOG_CTRL, 8'h00);
        wait_hi(60, 1'b1);
        check(k, 60);
        pulse(1'b0);
        pulse(1'b1);
        check({power_down_flag, time_out_flag, osc_driver_off, io_hold}, 4'h7);
        @(posedge ref_clk) src_req <= 4'h2;
        repeat (6) @(posedge ref_clk);
        #1 check(io_hold, 1'b1);
        @(posedge ref_clk) irq_enable <= 4'h2;
        wait_hi(6, 1'b0);
        check({wake_vector, io_hold}, 2'h2);
        // every wired source, global enable off: resume in line
        for (int s = 0; s < 4; s++) begin
            @(posedge ref_clk) src_req <= 4'h0;
            global_irq_enable <= 1'b0;
            irq_enable <= 4'h1 << s;
            pulse(1'b1);
            @(posedge ref_clk) src_req <= 4'h1 << s;
            wait_hi(6, 1'b0);
            check({k < 6, wake_vector}, 2'h2);
        end
        @(posedge ref_clk) src_req <= 4'h0;
        wr(ADDR_SW_WDOG_CTRL, 8'h01);
        pulse(1'b1);
        wait_hi(60, 1'b0);
        check({k < 60, time_out_flag, device_reset_req}, 3'h4);
        // clears closer than one 1:1 period keep the running watchdog from expiring
        for (int c = 0; c < 8; c++) begin
            pulse(1'b0);
            wait_hi(3, 1'b1);
            check(k, 3);
        end
        wr(ADDR_SW_WDOG_CTRL, 8'h00);
        pulse(1'b1);
        @(posedge ref_clk) external_reset_pin <= 1'b1;
        @(posedge ref_clk) external_reset_pin <= 1'b0;
        #1 check({device_reset_req, wake_resume}, 2'h2);
        reset_with(8'h0f, OSC_RC);
        measure(8'h0e, 2);
        reset_with(8'h01, OSC_RC);
        measure(8'h00, 256);
        // crystal mode waits out the oscillator start-up before resuming
        reset_with(8'h00, OSC_HS);
        pulse(1'b1);
        @(posedge ref_clk) src_req <= 4'h1;
        irq_enable <= 4'h1;
        wait_hi(1100, 1'b0);
        check(k >= 1024 && k <= 1035, 1'b1);
        tally_and_finish();
    end
endmodule : tb_wsw_ctrl
